/* include/dma_pkg.sv */
// constants shared by the multiply-add tile: register map, fields, modes
// assumes one clock domain and an apb master in the fabric
package dma_pkg;
  // register byte offsets
  localparam logic [7:0] DMA_CFG_OFS = 8'h00;
  localparam logic [7:0] DMA_SEL_OFS = 8'h04;
  localparam logic [7:0] DMA_STAT_OFS = 8'h08;
  // cfg field positions
  localparam int DMA_CFG_MODE_LSB = 0;
  localparam int DMA_CFG_SIZE_LSB = 3;
  localparam int DMA_CFG_INREG_BIT = 5;
  localparam int DMA_CFG_SHA_BIT = 6;
  localparam int DMA_CFG_SHB_BIT = 7;
  localparam int DMA_CFG_PIPE_BIT = 8;
  localparam int DMA_CFG_OUTREG_BIT = 9;
  localparam int DMA_CFG_SIGNST_LSB = 10;
  localparam int DMA_CFG_ADDST_LSB = 12;
  localparam int DMA_CFG_SLDST_LSB = 14;
  localparam int DMA_CFG_BITS = 16;
  // sel fields: six bits per bank, clock/clear/enable index
  localparam int DMA_SEL_BANK_W = 6;
  localparam int DMA_SEL_CLK_LSB = 0;
  localparam int DMA_SEL_ACLR_LSB = 2;
  localparam int DMA_SEL_ENA_LSB = 4;
  localparam int DMA_SEL_BITS = 24;
  localparam int DMA_BANK_A = 0;
  localparam int DMA_BANK_B = 1;
  localparam int DMA_BANK_PIPE = 2;
  localparam int DMA_BANK_OUT = 3;
  // reset values
  localparam logic [DMA_CFG_BITS-1:0] DMA_CFG_RST = 16'h0000;
  localparam logic [DMA_SEL_BITS-1:0] DMA_SEL_RST = 24'h000000;
  // adder modes
  localparam logic [2:0] DMA_MODE_DIRECT = 3'h0;
  localparam logic [2:0] DMA_MODE_ACCUM = 3'h1;
  localparam logic [2:0] DMA_MODE_ADD2 = 3'h2;
  localparam logic [2:0] DMA_MODE_ADD4 = 3'h3;
  // multiplier sizes
  localparam logic [1:0] DMA_SIZE_NARROW = 2'h0;
  localparam logic [1:0] DMA_SIZE_MEDIUM = 2'h1;
  localparam logic [1:0] DMA_SIZE_WIDE = 2'h2;
  // widths
  localparam int DMA_OP_W = 72;
  localparam int DMA_RES_W = 144;
  localparam int DMA_ACC_W = 52;
  localparam int DMA_NW = 9;
  localparam int DMA_MW = 18;
  typedef enum logic [1:0] {DMA_APB_IDLE_T, DMA_APB_ANS_T} dma_apb_t;
endpackage

/* rtl/dma_tile.sv */
// multiply-add tile: input banks, multipliers, pipeline, adders, accumulators, output
// assumes fabric controls synchronous to ref_clk; registers reached over apb
`timescale 1ns/1ns
module dma_tile
  import dma_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // block-wide controls
  input wire logic [3:0] blk_clk_en,
  input wire logic [3:0] blk_aclr,
  input wire logic [3:0] blk_ena,
  // operands and dynamic controls
  input wire logic [DMA_OP_W-1:0] data_a,
  input wire logic [DMA_OP_W-1:0] data_b,
  input wire logic [DMA_MW-1:0] shift_in_a,
  input wire logic [DMA_MW-1:0] shift_in_b,
  input wire logic sign_a,
  input wire logic sign_b,
  input wire logic [1:0] addnsub,
  input wire logic [1:0] accum_sload,
  // results
  output logic [DMA_RES_W-1:0] result,
  output logic [1:0] overflow,
  output logic [DMA_MW-1:0] shift_chain_out_a,
  output logic [DMA_MW-1:0] shift_chain_out_b
);
  logic [DMA_CFG_BITS-1:0] cfg_ff;
  logic [DMA_SEL_BITS-1:0] sel_ff;
  logic [DMA_OP_W-1:0] reg_a_ff, reg_b_ff, nxt_reg_a, nxt_reg_b;
  logic [DMA_RES_W-1:0] prod_ff, prod_raw, prod_use, nxt_result, result_ff;
  logic [DMA_ACC_W-1:0] acc_ff [2];
  logic [DMA_ACC_W-1:0] nxt_acc [2];
  logic [1:0] ovf_nxt, overflow_ff;
  logic [DMA_MW-1:0] chain_a_ff, chain_b_ff;
  logic [1:0] sa_ff, sb_ff;
  logic [3:0] ans_ff, sld_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  dma_apb_t apb_st_ff;
  logic [3:0] tick, clr;
  logic [2:0] mode;
  logic [1:0] size;
  logic wide, accm, shift_a, shift_b, out_reg, sa, sb, psign;
  logic [1:0] ans_use, sld_use;
  logic [DMA_OP_W-1:0] op_a, op_b;

  // bank controls: a "clock" choice is a clock-rate enable in this single-clock build
  for (genvar k = 0; k < 4; k++)
  begin : g_bank
    logic [5:0] s;
    assign s = sel_ff[k*DMA_SEL_BANK_W +: DMA_SEL_BANK_W];
    assign tick[k] = blk_clk_en[s[DMA_SEL_CLK_LSB +: 2]] & blk_ena[s[DMA_SEL_ENA_LSB +: 2]];
    assign clr[k] = blk_aclr[s[DMA_SEL_ACLR_LSB +: 2]];
  end

  assign size = cfg_ff[DMA_CFG_SIZE_LSB +: 2];
  assign wide = (size == DMA_SIZE_WIDE);
  // wide has no adder use, so any mode there collapses to direct
  assign mode = wide ? DMA_MODE_DIRECT : cfg_ff[DMA_CFG_MODE_LSB +: 3];
  assign accm = (mode == DMA_MODE_ACCUM);
  assign shift_a = cfg_ff[DMA_CFG_SHA_BIT] & ~wide;
  assign shift_b = cfg_ff[DMA_CFG_SHB_BIT] & ~wide;
  assign out_reg = cfg_ff[DMA_CFG_OUTREG_BIT] | accm;

  // apb slave, one wait state: answer flops make every bus output registered
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      apb_st_ff <= DMA_APB_IDLE_T;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
    else
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      apb_st_ff <= DMA_APB_IDLE_T;
      if (psel && penable && apb_st_ff == DMA_APB_IDLE_T)
      begin
        apb_st_ff <= DMA_APB_ANS_T;
        pready_ff <= 1'b1;
        prdata_ff <= 32'h00000000;
        case (paddr)
          DMA_CFG_OFS: prdata_ff <= {16'h0000, cfg_ff};
          DMA_SEL_OFS: prdata_ff <= {8'h00, sel_ff};
          DMA_STAT_OFS: prdata_ff <= {27'h0000000, overflow_ff, mode};
          default: pslverr_ff <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cfg_ff <= DMA_CFG_RST;
      sel_ff <= DMA_SEL_RST;
    end
    else if (psel && penable && pready_ff && pwrite)
    begin
      if (paddr == DMA_CFG_OFS)
        cfg_ff <= pwdata[DMA_CFG_BITS-1:0];
      if (paddr == DMA_SEL_OFS)
        sel_ff <= pwdata[DMA_SEL_BITS-1:0];
    end
  end

  // input banks: parallel load or shift one lane per tick
  always_comb
  begin
    nxt_reg_a = data_a;
    nxt_reg_b = data_b;
    if (shift_a)
      nxt_reg_a = (size == DMA_SIZE_NARROW) ? {reg_a_ff[62:0], shift_in_a[DMA_NW-1:0]} :
                  {reg_a_ff[53:0], shift_in_a};
    if (shift_b)
      nxt_reg_b = (size == DMA_SIZE_NARROW) ? {reg_b_ff[62:0], shift_in_b[DMA_NW-1:0]} :
                  {reg_b_ff[53:0], shift_in_b};
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || clr[DMA_BANK_A])
    begin
      reg_a_ff <= '0;
      chain_a_ff <= '0;
    end
    else if (tick[DMA_BANK_A])
    begin
      reg_a_ff <= nxt_reg_a;
      // chain leaves from the last lane; the next tile may end it anywhere
      chain_a_ff <= (size == DMA_SIZE_NARROW) ? {9'h000, nxt_reg_a[71:63]} : nxt_reg_a[71:54];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || clr[DMA_BANK_B])
    begin
      reg_b_ff <= '0;
      chain_b_ff <= '0;
    end
    else if (tick[DMA_BANK_B])
    begin
      reg_b_ff <= nxt_reg_b;
      chain_b_ff <= (size == DMA_SIZE_NARROW) ? {9'h000, nxt_reg_b[71:63]} : nxt_reg_b[71:54];
    end
  end

  // shift mode needs the registers, so it overrides a bypassed bank
  assign op_a = (cfg_ff[DMA_CFG_INREG_BIT] | shift_a) ? reg_a_ff : data_a;
  assign op_b = (cfg_ff[DMA_CFG_INREG_BIT] | shift_b) ? reg_b_ff : data_b;

  // control delay lines: stage one on bank a, stage two on the pipeline bank
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || clr[DMA_BANK_A])
    begin
      sa_ff[0] <= 1'b0;
      sb_ff[0] <= 1'b0;
      ans_ff[1:0] <= 2'h0;
      sld_ff[1:0] <= 2'h0;
    end
    else if (tick[DMA_BANK_A])
    begin
      sa_ff[0] <= sign_a;
      sb_ff[0] <= sign_b;
      ans_ff[1:0] <= addnsub;
      sld_ff[1:0] <= accum_sload;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || clr[DMA_BANK_PIPE])
    begin
      sa_ff[1] <= 1'b0;
      sb_ff[1] <= 1'b0;
      ans_ff[3:2] <= 2'h0;
      sld_ff[3:2] <= 2'h0;
    end
    else if (tick[DMA_BANK_PIPE])
    begin
      sa_ff[1] <= sa_ff[0];
      sb_ff[1] <= sb_ff[0];
      ans_ff[3:2] <= ans_ff[1:0];
      sld_ff[3:2] <= sld_ff[1:0];
    end
  end

  always_comb
  begin
    case (cfg_ff[DMA_CFG_SIGNST_LSB +: 2])
      2'h1: {sa, sb} = {sa_ff[0], sb_ff[0]};
      2'h2: {sa, sb} = {sa_ff[1], sb_ff[1]};
      default: {sa, sb} = {sign_a, sign_b};
    endcase
    case (cfg_ff[DMA_CFG_ADDST_LSB +: 2])
      2'h1: ans_use = ans_ff[1:0];
      2'h2: ans_use = ans_ff[3:2];
      default: ans_use = addnsub;
    endcase
    case (cfg_ff[DMA_CFG_SLDST_LSB +: 2])
      2'h1: sld_use = sld_ff[1:0];
      2'h2: sld_use = sld_ff[3:2];
      default: sld_use = accum_sload;
    endcase
  end
  assign psign = sa | sb;

  // multipliers: one extra sign bit per operand gives exact mixed-sign products
  logic [DMA_RES_W-1:0] p9, p18;
  logic [71:0] p36;
  for (genvar i = 0; i < 8; i++)
  begin : g_narrow
    logic signed [9:0] ea, eb;
    logic signed [19:0] pp;
    assign ea = {sa & op_a[9*i+8], op_a[9*i +: 9]};
    assign eb = {sb & op_b[9*i+8], op_b[9*i +: 9]};
    assign pp = ea * eb;
    assign p9[18*i +: 18] = pp[17:0];
  end
  for (genvar j = 0; j < 4; j++)
  begin : g_medium
    logic signed [18:0] ea, eb;
    logic signed [37:0] pp;
    assign ea = {sa & op_a[18*j+17], op_a[18*j +: 18]};
    assign eb = {sb & op_b[18*j+17], op_b[18*j +: 18]};
    assign pp = ea * eb;
    assign p18[36*j +: 36] = pp[35:0];
  end
  if (1'b1)
  begin : g_wide
    logic signed [36:0] ea, eb;
    logic signed [73:0] pp;
    assign ea = {sa & op_a[35], op_a[35:0]};
    assign eb = {sb & op_b[35], op_b[35:0]};
    assign pp = ea * eb;
    assign p36 = pp[71:0];
  end
  assign prod_raw = (size == DMA_SIZE_NARROW) ? p9 : (wide ? {72'h0, p36} : p18);

  // pipeline register; bypassed unless the pipe bit is set, in wide size as in the others
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || clr[DMA_BANK_PIPE])
      prod_ff <= '0;
    else if (tick[DMA_BANK_PIPE])
      prod_ff <= prod_raw;
  end
  assign prod_use = cfg_ff[DMA_CFG_PIPE_BIT] ? prod_ff : prod_raw;

  // first-level adders and summation
  logic [20:0] r9 [4];
  logic [20:0] s9 [2];
  logic [38:0] r18 [2];
  logic [38:0] s18;
  for (genvar i = 0; i < 4; i++)
  begin : g_add9
    logic [20:0] x, y;
    assign x = {{3{psign & prod_use[36*i+17]}}, prod_use[36*i +: 18]};
    assign y = {{3{psign & prod_use[36*i+35]}}, prod_use[36*i+18 +: 18]};
    assign r9[i] = ans_use[i/2] ? x + y : x - y;
  end
  for (genvar j = 0; j < 2; j++)
  begin : g_add18
    logic [38:0] x, y;
    assign x = {{3{psign & prod_use[72*j+35]}}, prod_use[72*j +: 36]};
    assign y = {{3{psign & prod_use[72*j+71]}}, prod_use[72*j+36 +: 36]};
    assign r18[j] = ans_use[j] ? x + y : x - y;
    assign s9[j] = r9[2*j] + r9[2*j+1];
  end
  assign s18 = r18[0] + r18[1];

  // accumulators: medium uses lanes 1 and 3, narrow lanes 3 and 7
  for (genvar k = 0; k < 2; k++)
  begin : g_acc
    logic [53:0] opx, accx, sum;
    always_comb
    begin
      if (size == DMA_SIZE_NARROW)
        opx = {{36{psign & prod_use[72*k+71]}}, prod_use[72*k+54 +: 18]};
      else
        opx = {{18{psign & prod_use[72*k+71]}}, prod_use[72*k+36 +: 36]};
      accx = {{2{psign & acc_ff[k][DMA_ACC_W-1]}}, acc_ff[k]};
      sum = ans_use[k] ? accx + opx : accx - opx;
      // outside the 52-bit range of the chosen signedness
      ovf_nxt[k] = psign ? (sum[53:51] != 3'h0 && sum[53:51] != 3'h7) : (sum[53:52] != 2'h0);
      nxt_acc[k] = sld_use[k] ? opx[DMA_ACC_W-1:0] : sum[DMA_ACC_W-1:0];
    end
    // output bank holds the accumulator, so its value is the fed-back output
    always_ff @(posedge ref_clk)
    begin
      if (!rst_n || clr[DMA_BANK_OUT])
        acc_ff[k] <= '0;
      else if (tick[DMA_BANK_OUT] && accm)
        acc_ff[k] <= nxt_acc[k];
    end
  end

  // output select
  always_comb
  begin
    nxt_result = '0;
    case (mode)
      DMA_MODE_ACCUM:
        nxt_result = {40'h0, nxt_acc[1], nxt_acc[0]};
      DMA_MODE_ADD2:
        if (size == DMA_SIZE_NARROW)
          for (int i = 0; i < 4; i++)
            nxt_result[36*i +: 21] = r9[i];
        else
          for (int j = 0; j < 2; j++)
            nxt_result[72*j +: 39] = r18[j];
      DMA_MODE_ADD4:
        if (size == DMA_SIZE_NARROW)
        begin
          nxt_result[20:0] = s9[0];
          nxt_result[92:72] = s9[1];
        end
        else
          nxt_result[38:0] = s18;
      default:
        nxt_result = prod_use;
    endcase
  end

  // bypassed output still passes one flop so ports stay registered
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || (out_reg && clr[DMA_BANK_OUT]))
    begin
      result_ff <= '0;
      overflow_ff <= 2'h0;
    end
    else if (!out_reg || tick[DMA_BANK_OUT])
    begin
      result_ff <= nxt_result;
      overflow_ff <= accm ? ovf_nxt & ~sld_use : 2'h0;
    end
  end

  assign result = result_ff;
  assign overflow = overflow_ff;
  assign shift_chain_out_a = chain_a_ff;
  assign shift_chain_out_b = chain_b_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  default clocking dck @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_wide_no_shift: assert property (wide |-> !shift_a && !shift_b)
    else $error("shift mode active in wide size");
  chk_accum_out_reg: assert property (accm |-> out_reg)
    else $error("accumulate without output register");
  chk_sload_replace: assert property (accm && tick[DMA_BANK_OUT] && !clr[DMA_BANK_OUT] && sld_use[0]
    |=> acc_ff[0] == $past(g_acc[0].opx[DMA_ACC_W-1:0]))
    else $error("accumulator load did not take the product");
  chk_ovf_clears: assert property (accm && tick[DMA_BANK_OUT] && !clr[DMA_BANK_OUT] && !ovf_nxt[0]
    |=> !overflow_ff[0])
    else $error("overflow flag held instead of following");
  chk_apb_answer: assert property (psel && penable && !pready_ff |=> pready_ff ##1 !pready_ff)
    else $error("apb answer not one cycle after access");
  chk_clear_zero: assert property (clr[DMA_BANK_A] |=> reg_a_ff == '0)
    else $error("clear did not zero input bank a");
  chk_shift_chain: assert property (shift_a && size == DMA_SIZE_NARROW && tick[DMA_BANK_A] && !clr[DMA_BANK_A]
    |=> reg_a_ff[17:9] == $past(reg_a_ff[8:0]))
    else $error("shift chain did not advance one lane");
  chk_unsigned_prod: assert property (!sa && !sb |-> p9[17:0] == 18'(op_a[8:0] * op_b[8:0]))
    else $error("unsigned narrow product wrong");
  chk_direct_out: assert property (mode == DMA_MODE_DIRECT && !out_reg |=> result_ff == $past(prod_use))
    else $error("direct mode result is not the product");
endmodule // dma_tile

/* tb/dma_fabric.sv */
// fabric-side partner: keeps a sticky copy of the tile's overflow pulses
// assumes overflow is registered on ref_clk
`timescale 1ns/1ns
module dma_fabric
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // tile flags
  input wire logic [1:0] overflow,
  input wire logic clr_hold,
  output logic [1:0] ovf_hold_ff
);
  // the tile flag is a pulse, so the fabric must hold it
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || clr_hold)
      ovf_hold_ff <= 2'h0;
    else
      ovf_hold_ff <= ovf_hold_ff | overflow;
  end
endmodule // dma_fabric

/* tb/testbench.sv */
// self-checking bench for the multiply-add tile, apb master and operand driver
// assumes one clock; every tick and enable held high unless a test says otherwise
`timescale 1ns/1ns
module testbench;
  import dma_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] blk_clk_en = 4'hf, blk_aclr = 4'h0, blk_ena = 4'hf;
  logic [DMA_OP_W-1:0] data_a = '0, data_b = '0;
  logic [DMA_MW-1:0] shift_in_a = '0, shift_in_b = '0, sh_a, sh_b;
  logic sign_a = 1'b0, sign_b = 1'b0, go = 1'b0;
  logic [1:0] addnsub = 2'h3, accum_sload = 2'h0, overflow, ovf_hold;
  logic [DMA_RES_W-1:0] result;
  logic [DMA_RES_W-1:0] exp_q[$];
  logic [3:0] go_sh = 4'h0;
  int lat = 1, errors = 0, checked = 0;

  initial forever #4 ref_clk = ~ref_clk;

  dma_tile i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .blk_clk_en(blk_clk_en), .blk_aclr(blk_aclr), .blk_ena(blk_ena), .data_a(data_a), .data_b(data_b),
    .shift_in_a(shift_in_a), .shift_in_b(shift_in_b), .sign_a(sign_a), .sign_b(sign_b),
    .addnsub(addnsub), .accum_sload(accum_sload), .result(result), .overflow(overflow),
    .shift_chain_out_a(sh_a), .shift_chain_out_b(sh_b));
  dma_fabric i_fab (.ref_clk(ref_clk), .rst_n(rst_n), .overflow(overflow), .clr_hold(1'b0),
    .ovf_hold_ff(ovf_hold));

  task automatic stop_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(string nm, logic [DMA_RES_W-1:0] e, logic [DMA_RES_W-1:0] s);
    checked++;
    if (e !== s)
    begin
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
      errors++;
    end
  endtask

  // result notes are taken off the queue once the pipeline tap says they are due
  always @(posedge ref_clk) go_sh <= {go_sh[2:0], go};
  always @(negedge ref_clk)
    if (go_sh[lat-1] && exp_q.size() > 0)
      check("result", exp_q.pop_front(), result);

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] e, logic ee);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20)
    begin
      errors++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!w)
      check("prdata", e, prdata);
    check("pslverr", ee, pslverr);
  endtask

  function automatic logic signed [73:0] sp(logic [35:0] x, logic [35:0] y, int w, logic s1, logic s2);
    logic signed [73:0] u, v;
    u = {38'h0, x} & ((74'sd1 << w) - 74'sd1);
    v = {38'h0, y} & ((74'sd1 << w) - 74'sd1);
    if (s1 && x[w-1])
      u = u - (74'sd1 << w);
    if (s2 && y[w-1])
      v = v - (74'sd1 << w);
    return u * v;
  endfunction

  function automatic logic [DMA_RES_W-1:0] put(logic signed [73:0] v, int fw, int pos);
    return DMA_RES_W'(v & ((74'sd1 << fw) - 74'sd1)) << pos;
  endfunction

  function automatic logic [DMA_RES_W-1:0] expect_res(logic [2:0] m, logic [1:0] z, logic [71:0] a,
    logic [71:0] b, logic s1, logic s2, logic [1:0] an);
    logic [DMA_RES_W-1:0] r;
    logic signed [73:0] p[8];
    int w, n;
    w = (z == DMA_SIZE_NARROW) ? DMA_NW : (z == DMA_SIZE_MEDIUM) ? DMA_MW : 36;
    n = (z == DMA_SIZE_WIDE) ? 1 : 72 / w;
    r = '0;
    for (int i = 0; i < n; i++)
      p[i] = sp(36'(a >> (w * i)), 36'(b >> (w * i)), w, s1, s2);
    for (int i = 0; i < n; i++)
      if (m == DMA_MODE_DIRECT)
        r = r | put(p[i], 2 * w, 2 * w * i);
      else if (m == DMA_MODE_ADD2 && i < n / 2)
        r = r | put(p[2*i] + ((w == DMA_NW ? an[i/2] : an[i]) ? p[2*i+1] : -p[2*i+1]), 2 * w + 3, 4 * w * i);
      else if (m == DMA_MODE_ADD4 && i < n / 4)
        r = r | put(p[4*i] + p[4*i+1] + p[4*i+2] + p[4*i+3], 2 * w + 3, 72 * i);
    return r;
  endfunction

  task automatic apply(logic [71:0] a, logic [71:0] b, logic s1, logic s2, logic [1:0] an, logic [1:0] ld,
    logic [DMA_RES_W-1:0] e);
    @(posedge ref_clk);
    data_a <= a;
    data_b <= b;
    sign_a <= s1;
    sign_b <= s2;
    addnsub <= an;
    accum_sload <= ld;
    go <= 1'b1;
    exp_q.push_back(e);
  endtask

  task automatic idle();
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic run(logic [2:0] m, logic [1:0] z, logic [15:0] x, int l);
    logic [2:0] em;
    logic [71:0] a, b;
    logic [1:0] an;
    em = (z == DMA_SIZE_WIDE) ? DMA_MODE_DIRECT : m;
    apb(1'b1, DMA_CFG_OFS, {16'h0, x | (16'(z) << DMA_CFG_SIZE_LSB) | 16'(m)}, 32'h0, 1'b0);
    apb(1'b0, DMA_STAT_OFS, 32'h0, {29'h0, em}, 1'b0);
    lat = l;
    for (int i = 0; i < 12; i++)
    begin
      a = 72'({$urandom, $urandom, $urandom});
      b = 72'({$urandom, $urandom, $urandom});
      an = (m == DMA_MODE_ADD4) ? 2'h3 : 2'($urandom);
      apply(a, b, i[0], i[1], an, 2'h0, expect_res(em, z, a, b, i[0], i[1], an));
    end
    idle();
    $display("test mode %0d size %0d done", m, z);
  endtask

  task automatic accum_test();
    logic signed [73:0] acc[2], p;
    logic [71:0] a, b;
    logic [1:0] ld;
    apb(1'b1, DMA_CFG_OFS, 32'h9, 32'h0, 1'b0);
    apb(1'b0, DMA_STAT_OFS, 32'h0, 32'h1, 1'b0);
    // accumulator and output flops load the same sum on one edge, so no extra stage
    lat = 1;
    for (int i = 0; i < 6; i++)
    begin
      a = 72'({$urandom, $urandom, $urandom});
      b = 72'({$urandom, $urandom, $urandom});
      ld = (i == 0) ? 2'h3 : (i == 3) ? 2'h1 : 2'h0;
      for (int k = 0; k < 2; k++)
      begin
        p = sp(36'(a >> (36 * k + 18)), 36'(b >> (36 * k + 18)), DMA_MW, 1'b0, 1'b0);
        acc[k] = ld[k] ? p : acc[k] + p;
      end
      apply(a, b, 1'b0, 1'b0, 2'h3, ld, {40'h0, acc[1][51:0], acc[0][51:0]});
    end
    idle();
    check("overflow", 2'h0, {overflow, ovf_hold});
    $display("test accumulate done");
  endtask

  task automatic misc_test();
    logic [17:0] v;
    int n;
    // out bank takes clear index 2, so clear 0 must leave the result alone
    apb(1'b1, DMA_SEL_OFS, 32'hff20_0000, 32'h0, 1'b0);
    apb(1'b0, DMA_SEL_OFS, 32'h0, 32'h0020_0000, 1'b0);
    apb(1'b1, DMA_CFG_OFS, 32'h0200, 32'h0, 1'b0);
    lat = 1;
    apply({72{1'b1}}, {72{1'b1}}, 1'b0, 1'b0, 2'h3, 2'h0, {8{18'h3fc01}});
    idle();
    blk_aclr <= 4'h1;
    @(posedge ref_clk);
    blk_aclr <= 4'h4;
    @(negedge ref_clk);
    check("result_kept", {8{18'h3fc01}}, result);
    @(posedge ref_clk);
    blk_aclr <= 4'h0;
    @(negedge ref_clk);
    check("result_cleared", '0, result);
    apb(1'b1, DMA_CFG_OFS, 32'h0068, 32'h0, 1'b0);
    v = 18'($urandom) | 18'h1;
    @(posedge ref_clk);
    shift_in_a <= v;
    @(posedge ref_clk);
    shift_in_a <= 18'h0;
    n = 0;
    while (sh_a !== v && n < 10)
    begin
      @(negedge ref_clk);
      n++;
    end
    check("shift_out_a", v, sh_a);
    check("shift_out_b", 18'h3ffff, sh_b);
    $display("test clear and shift done");
  endtask

  initial
  begin
    #400000;
    errors++;
    stop_test();
  end

  initial
  begin
    void'($urandom(8475));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, DMA_CFG_OFS, 32'h0, 32'h0, 1'b0);
    apb(1'b0, DMA_SEL_OFS, 32'h0, 32'h0, 1'b0);
    apb(1'b1, 8'h0c, 32'h1, 32'h0, 1'b1);
    apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
    apb(1'b1, DMA_CFG_OFS, 32'hffff_0320, 32'h0, 1'b0);
    apb(1'b0, DMA_CFG_OFS, 32'h0, 32'h0320, 1'b0);
    $display("test registers done");
    for (int m = 0; m < 4; m++)
      for (int z = 0; z < 3; z++)
        if (m != 1)
          run(3'(m), 2'(z), 16'h0, 1);
    run(DMA_MODE_DIRECT, DMA_SIZE_NARROW, 16'h0720, 3);
    run(DMA_MODE_ADD2, DMA_SIZE_NARROW, 16'h1420, 2);
    run(DMA_MODE_ADD4, DMA_SIZE_MEDIUM, 16'h0200, 1);
    accum_test();
    misc_test();
    stop_test();
  end
endmodule // testbench
